//--- rtl/usbsp_top.v
// Suspend indicators, activity toggles and their register port
// How it works
// - Transmit toggle pin toggles during UART transmit, idles high.
// - Receive toggle pin toggles during UART receive, idles high.
// - Each activity pin selects between GPIO and its toggle function.
// - Active-high sleep pin is high in suspend, low otherwise.
// - Active-low sleep pin is the complement of the high one outside reset.
// - Bus suspend signalling enters suspend and asserts both sleep pins.
// - After reset, sleep pins stay asserted until configuration completes.
// - Resume, bus reset or device resume leaves suspend when configured.
// - During reset both sleep pins float with a weak pull up.
// - Suspend level and drive type of the activity pins come from OTP config.
// - Activity pins toggle at a fixed 10 Hz rate.
//
// Design decisions made here: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "usbsp_consts.vh"

module usbsp_top
(
   input  wire                     ref_clk,
   input  wire                     srst,
   input  wire                     clk_en,
   input  wire                     bus_suspend,
   input  wire                     bus_resume,
   input  wire                     dev_resume,
   input  wire                     bus_reset,
   input  wire                     configured,
   input  wire                     uart_tx_busy,
   input  wire                     uart_rx_busy,
   input  wire                     otp_susp_level4,
   input  wire                     otp_susp_level5,
   input  wire                     otp_susp_od4,
   input  wire                     otp_susp_od5,
   input  wire                     gpio4_in,
   input  wire                     gpio5_in,
   input  wire [`USBSP_ADDR_W-1:0] reg_addr,
   input  wire [`USBSP_DATA_W-1:0] reg_wdata,
   input  wire                     reg_wr,
   input  wire                     reg_rd,
   output reg  [`USBSP_DATA_W-1:0] reg_rdata,
   output reg                      irq,
   output reg                      sleep_hi_out,
   output reg                      sleep_hi_oe_n,
   output reg                      sleep_lo_n_out,
   output reg                      sleep_lo_n_oe_n,
   output reg                      tx_activity_toggle_out,
   output reg                      tx_activity_toggle_oe_n,
   output reg                      rx_activity_toggle_out,
   output reg                      rx_activity_toggle_oe_n
);

   wire       suspended;
   wire       tx_tog;
   wire       rx_tog;
   reg        susp_q;
   reg        conf_q;
   reg  [5:0] ctrl_q;
   reg  [`USBSP_IRQ_W-1:0] irq_stat_q;
   reg  [`USBSP_IRQ_W-1:0] irq_mask_q;
   reg  [`USBSP_IRQ_W-1:0] irq_ev;
   reg  [`USBSP_IRQ_W-1:0] irq_stat_d;
   reg  [`USBSP_DATA_W-1:0] rdata_d;
   reg        pin4_out;
   reg        pin4_oe_n;
   reg        pin5_out;
   reg        pin5_oe_n;

   function is_addr;
      input [`USBSP_ADDR_W-1:0] a;
      input [`USBSP_ADDR_W-1:0] r;
      begin
         is_addr = (a == r);
      end
   endfunction

   usbsp_susp_fsm u_fsm
   (
      .ref_clk     (ref_clk),
      .srst        (srst),
      .clk_en      (clk_en),
      .bus_suspend (bus_suspend),
      .bus_resume  (bus_resume),
      .dev_resume  (dev_resume),
      .bus_reset   (bus_reset),
      .configured  (configured),
      .suspended   (suspended)
   );

   usbsp_toggle u_tx_tog
   (
      .ref_clk  (ref_clk),
      .srst     (srst),
      .clk_en   (clk_en),
      .active   (uart_tx_busy),
      .toggle_q (tx_tog)
   );

   usbsp_toggle u_rx_tog
   (
      .ref_clk  (ref_clk),
      .srst     (srst),
      .clk_en   (clk_en),
      .active   (uart_rx_busy),
      .toggle_q (rx_tog)
   );

   // Events for the interrupt status register
   always @*
   begin
      irq_ev = {`USBSP_IRQ_W{1'b0}};
      irq_ev[`USBSP_IRQ_SUSP_ENTER] = suspended & ~susp_q;
      irq_ev[`USBSP_IRQ_SUSP_EXIT]  = ~suspended & susp_q;
      irq_ev[`USBSP_IRQ_CONFIGURED] = configured & ~conf_q;
   end

   // Read clears status, a new event in the same cycle wins
   always @*
   begin
      irq_stat_d = irq_stat_q;
      if (reg_rd && is_addr(reg_addr, `USBSP_REG_IRQ_STAT))
         irq_stat_d = {`USBSP_IRQ_W{1'b0}};
      irq_stat_d = irq_stat_d | irq_ev;
   end

   always @*
   begin
      rdata_d = {`USBSP_DATA_W{1'b0}};
      if (is_addr(reg_addr, `USBSP_REG_CTRL))
         rdata_d[5:0] = ctrl_q;
      else if (is_addr(reg_addr, `USBSP_REG_STATUS))
         rdata_d[3:0] = {uart_rx_busy, uart_tx_busy, conf_q, susp_q};
      else if (is_addr(reg_addr, `USBSP_REG_IRQ_STAT))
         rdata_d[`USBSP_IRQ_W-1:0] = irq_stat_q;
      else if (is_addr(reg_addr, `USBSP_REG_IRQ_MASK))
         rdata_d[`USBSP_IRQ_W-1:0] = irq_mask_q;
   end

   // Pin muxing between GPIO, toggle function and OTP suspend setting
   always @*
   begin
      if (susp_q)
      begin
         pin4_out  = otp_susp_level4;
         pin4_oe_n = otp_susp_od4 & otp_susp_level4;
         pin5_out  = otp_susp_level5;
         pin5_oe_n = otp_susp_od5 & otp_susp_level5;
      end
      else
      begin
         if (ctrl_q[`USBSP_CTRL_TX_SEL])
         begin
            pin4_out  = tx_tog;
            pin4_oe_n = 1'b0;
         end
         else
         begin
            pin4_out  = ctrl_q[`USBSP_CTRL_GPIO4_OUT];
            pin4_oe_n = ~ctrl_q[`USBSP_CTRL_GPIO4_OE];
         end
         if (ctrl_q[`USBSP_CTRL_RX_SEL])
         begin
            pin5_out  = rx_tog;
            pin5_oe_n = 1'b0;
         end
         else
         begin
            pin5_out  = ctrl_q[`USBSP_CTRL_GPIO5_OUT];
            pin5_oe_n = ~ctrl_q[`USBSP_CTRL_GPIO5_OE];
         end
      end
   end

   always @(posedge ref_clk)
   begin
      if (srst)
      begin
         susp_q                  <= 1'b1;
         conf_q                  <= 1'b0;
         ctrl_q                  <= `USBSP_CTRL_RESET;
         irq_stat_q              <= {`USBSP_IRQ_W{1'b0}};
         irq_mask_q              <= {`USBSP_IRQ_W{1'b0}};
         reg_rdata               <= {`USBSP_DATA_W{1'b0}};
         irq                     <= 1'b0;
         sleep_hi_out            <= 1'b1;
         sleep_hi_oe_n           <= 1'b1;
         sleep_lo_n_out          <= 1'b1;
         sleep_lo_n_oe_n         <= 1'b1;
         tx_activity_toggle_out  <= 1'b1;
         tx_activity_toggle_oe_n <= 1'b1;
         rx_activity_toggle_out  <= 1'b1;
         rx_activity_toggle_oe_n <= 1'b1;
      end
      else if (clk_en)
      begin
         susp_q     <= suspended;
         conf_q     <= configured;
         irq_stat_q <= irq_stat_d;
         if (reg_wr && is_addr(reg_addr, `USBSP_REG_CTRL))
            ctrl_q <= reg_wdata[5:0];
         if (reg_wr && is_addr(reg_addr, `USBSP_REG_IRQ_MASK))
            irq_mask_q <= reg_wdata[`USBSP_IRQ_W-1:0];
         reg_rdata <= reg_rd ? rdata_d : {`USBSP_DATA_W{1'b0}};
         irq       <= |(irq_stat_d & irq_mask_q);
         sleep_hi_out            <= suspended;
         sleep_hi_oe_n           <= 1'b0;
         sleep_lo_n_out          <= ~suspended;
         sleep_lo_n_oe_n         <= 1'b0;
         tx_activity_toggle_out  <= pin4_out;
         tx_activity_toggle_oe_n <= pin4_oe_n;
         rx_activity_toggle_out  <= pin5_out;
         rx_activity_toggle_oe_n <= pin5_oe_n;
      end
   end

   // Data path between USB and UART lives outside this block
   wire unused_ok = gpio4_in ^ gpio5_in;

endmodule // usbsp_top

`default_nettype wire

//--- pkg/usbsp_consts.vh
// Constants for the suspend indicator and activity toggle block
`ifndef USBSP_CONSTS_VH
`define USBSP_CONSTS_VH

`define USBSP_CLK_HZ          125000000
`define USBSP_TOGGLE_HZ       10
// Half period of a 10 Hz toggle, in ref_clk cycles
`define USBSP_TOGGLE_HALF_CYC (`USBSP_CLK_HZ / (2 * `USBSP_TOGGLE_HZ))
`define USBSP_CNT_W           23

`define USBSP_ADDR_W          4
`define USBSP_DATA_W          32
`define USBSP_REG_CTRL        4'h0
`define USBSP_REG_STATUS      4'h4
`define USBSP_REG_IRQ_STAT    4'h8
`define USBSP_REG_IRQ_MASK    4'hC

`define USBSP_CTRL_TX_SEL     0
`define USBSP_CTRL_RX_SEL     1
`define USBSP_CTRL_GPIO4_OUT  2
`define USBSP_CTRL_GPIO5_OUT  3
`define USBSP_CTRL_GPIO4_OE   4
`define USBSP_CTRL_GPIO5_OE   5
`define USBSP_CTRL_RESET      6'h03

`define USBSP_IRQ_W           3
`define USBSP_IRQ_SUSP_ENTER  0
`define USBSP_IRQ_SUSP_EXIT   1
`define USBSP_IRQ_CONFIGURED  2

`endif

//--- rtl/usbsp_toggle.v
// Activity toggle generator for one direction
`timescale 1ns/100ps
`default_nettype none
`include "usbsp_consts.vh"

module usbsp_toggle
(
   input  wire ref_clk,
   input  wire srst,
   input  wire clk_en,
   input  wire active,
   output reg  toggle_q
);

   reg  [`USBSP_CNT_W-1:0] cnt_q;
   localparam [31:0]             HALF_M1_W = `USBSP_TOGGLE_HALF_CYC - 1;
   // Count fits the counter width, cut on purpose
   localparam [`USBSP_CNT_W-1:0] HALF_M1   = HALF_M1_W[`USBSP_CNT_W-1:0];

   always @(posedge ref_clk)
   begin
      if (srst)
      begin
         cnt_q    <= {`USBSP_CNT_W{1'b0}};
         toggle_q <= 1'b1;
      end
      else if (clk_en)
      begin
         if (!active)
         begin
            cnt_q    <= {`USBSP_CNT_W{1'b0}};
            toggle_q <= 1'b1;
         end
         else if (cnt_q == HALF_M1)
         begin
            cnt_q    <= {`USBSP_CNT_W{1'b0}};
            toggle_q <= ~toggle_q;
         end
         else
         begin
            cnt_q <= cnt_q + {{(`USBSP_CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end

endmodule // usbsp_toggle

`default_nettype wire

//--- rtl/usbsp_susp_fsm.v
// USB suspend state tracker
`timescale 1ns/100ps
`default_nettype none
`include "usbsp_consts.vh"

module usbsp_susp_fsm
(
   input  wire ref_clk,
   input  wire srst,
   input  wire clk_en,
   input  wire bus_suspend,
   input  wire bus_resume,
   input  wire dev_resume,
   input  wire bus_reset,
   input  wire configured,
   output wire suspended
);

   localparam [2:0] ST_UNCONF = 3'b001;
   localparam [2:0] ST_ACTIVE = 3'b010;
   localparam [2:0] ST_SUSP   = 3'b100;

   reg [2:0] state_q;
   reg [2:0] state_d;

   assign suspended = ~state_q[1];

   always @*
   begin
      state_d = state_q;
      case (state_q)
         ST_UNCONF:
            if (configured)
               state_d = ST_ACTIVE;
         ST_ACTIVE:
            if (bus_suspend)
               state_d = ST_SUSP;
         ST_SUSP:
            if (bus_resume || dev_resume || bus_reset)
               state_d = configured ? ST_ACTIVE : ST_UNCONF;
         default:
            state_d = ST_UNCONF;
      endcase
   end

   always @(posedge ref_clk)
   begin
      if (srst)
         state_q <= ST_UNCONF;
      else if (clk_en)
         state_q <= state_d;
   end

endmodule // usbsp_susp_fsm

`default_nettype wire

//--- test/usbsp_host_model.sv
// Host controller model driving the bus power events
`timescale 1ns/100ps
`default_nettype none
module usbsp_host_model
(
   input  wire logic ref_clk,
   output var logic  bus_suspend,
   output var logic  bus_resume,
   output var logic  bus_reset,
   output var logic  configured
);
   initial
   begin
      bus_suspend = 1'b0;
      bus_resume = 1'b0;
      bus_reset = 1'b0;
      configured = 1'b0;
   end
   task automatic suspend();
      @(posedge ref_clk);
      bus_suspend <= 1'b1;
   endtask
   task automatic set_config();
      @(posedge ref_clk);
      configured <= 1'b1;
   endtask
   // Host forgets the configuration, as around a device reset
   task automatic unconfig();
      @(posedge ref_clk);
      configured <= 1'b0;
   endtask
   // Kind 0 resume, 1 bus reset, 2 quiet bus for a device wake
   task automatic wake(input int kind);
      @(posedge ref_clk);
      bus_suspend <= 1'b0;
      bus_resume <= (kind == 0);
      bus_reset <= (kind == 1);
      @(posedge ref_clk);
      bus_resume <= 1'b0;
      bus_reset <= 1'b0;
   endtask
endmodule // usbsp_host_model
`default_nettype wire

//--- test/usbsp_chk_assertions.sv
// Assertions on sleep indicator and activity pins
`timescale 1ns/100ps
`default_nettype none
module usbsp_chk
(
   input wire logic        ref_clk,
   input wire logic        srst,
   input wire logic        clk_en,
   input wire logic        bus_suspend,
   input wire logic        bus_resume,
   input wire logic        bus_reset,
   input wire logic        configured,
   input wire logic        uart_tx_busy,
   input wire logic        uart_rx_busy,
   input wire logic [3:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        irq,
   input wire logic        sleep_hi_out,
   input wire logic        sleep_hi_oe_n,
   input wire logic        sleep_lo_n_out,
   input wire logic        sleep_lo_n_oe_n,
   input wire logic        tx_activity_toggle_out,
   input wire logic        rx_activity_toggle_out
);
   logic tx_sel_q;
   logic rx_sel_q;
   // Shadow of the toggle select bits
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         tx_sel_q <= 1'b1;
         rx_sel_q <= 1'b1;
      end
      else if (clk_en && reg_wr && reg_addr == 4'h0)
      begin
         tx_sel_q <= reg_wdata[0];
         rx_sel_q <= reg_wdata[1];
      end
   end
   default clocking @(posedge ref_clk); endclocking
   // Frozen cycles move nothing, so attempts across them are dropped
   default disable iff (srst || !clk_en);
   sequence s_tx_idle;
      (tx_sel_q && !sleep_hi_out && !uart_tx_busy) [*3];
   endsequence
   sequence s_rx_idle;
      (rx_sel_q && !sleep_hi_out && !uart_rx_busy) [*3];
   endsequence
   AST_SLEEP_COMPL: assert property (
      !$past(srst) |-> sleep_lo_n_out != sleep_hi_out) else $error("sleep pins equal");
   AST_RESET_FLOAT: assert property (
      @(posedge ref_clk) disable iff (1'b0) srst |=> sleep_hi_oe_n && sleep_lo_n_oe_n)
      else $error("sleep pins driven in reset");
   AST_RESET_ASLEEP: assert property (
      $fell(srst) |=> sleep_hi_out && !sleep_lo_n_out) else $error("awake after reset");
   AST_SUSP_ENTER: assert property (
      $rose(bus_suspend) |-> ##2 sleep_hi_out && !sleep_lo_n_out)
      else $error("suspend not entered");
   AST_SUSP_EXIT: assert property (
      ($rose(bus_resume) || $rose(bus_reset)) && configured && !bus_suspend
      |-> ##2 !sleep_hi_out) else $error("suspend not left");
   AST_TX_END_HIGH: assert property (
      tx_sel_q && !sleep_hi_out && $fell(uart_tx_busy) |-> ##2 tx_activity_toggle_out)
      else $error("tx pin not high after end");
   AST_TX_IDLE: assert property (s_tx_idle |-> tx_activity_toggle_out)
      else $error("tx pin low while idle");
   AST_RX_IDLE: assert property (s_rx_idle |-> rx_activity_toggle_out)
      else $error("rx pin low while idle");
   AST_FREEZE_HOLD: assert property (
      @(posedge ref_clk) disable iff (srst)
      !clk_en |=> $stable(sleep_hi_out) && $stable(sleep_lo_n_out) && $stable(irq)
      && $stable(tx_activity_toggle_out) && $stable(rx_activity_toggle_out))
      else $error("outputs moved while clock enable low");
endmodule // usbsp_chk
bind usbsp_top usbsp_chk u_usbsp_chk (.ref_clk, .srst, .clk_en, .bus_suspend, .bus_resume,
   .bus_reset, .configured, .uart_tx_busy, .uart_rx_busy, .reg_addr, .reg_wdata, .reg_wr, .irq,
   .sleep_hi_out, .sleep_hi_oe_n, .sleep_lo_n_out, .sleep_lo_n_oe_n, .tx_activity_toggle_out,
   .rx_activity_toggle_out);
`default_nettype wire

//--- test/test_usbsp_top.sv
// Directed test of sleep pins, activity pins and registers
`timescale 1ns/100ps
`default_nettype none
module test_usbsp_top;
   logic        ref_clk = 1'b0;
   logic        srst = 1'b1;
   logic        clk_en = 1'b1;
   logic        dev_resume = 1'b0;
   logic        uart_tx_busy = 1'b0;
   logic        uart_rx_busy = 1'b0;
   logic        otp_susp_level4 = 1'b1;
   logic        otp_susp_od4 = 1'b1;
   logic [3:0]  reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   wire logic   bus_suspend, bus_resume, bus_reset, configured, irq;
   wire logic [31:0] reg_rdata;
   wire logic   sleep_hi_out, sleep_hi_oe_n, sleep_lo_n_out, sleep_lo_n_oe_n;
   wire logic   tx_activity_toggle_out, tx_activity_toggle_oe_n;
   wire logic   rx_activity_toggle_out, rx_activity_toggle_oe_n;
   int          err_total = 0;
   int          n_tests = 0;
   always #4 ref_clk = ~ref_clk;
   usbsp_top u_usbsp_top (.ref_clk, .srst, .clk_en, .bus_suspend, .bus_resume,
      .dev_resume, .bus_reset, .configured, .uart_tx_busy, .uart_rx_busy, .otp_susp_level4,
      .otp_susp_level5(1'b1), .otp_susp_od4, .otp_susp_od5(1'b1), .gpio4_in(1'b0),
      .gpio5_in(1'b0), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
      .sleep_hi_out, .sleep_hi_oe_n, .sleep_lo_n_out, .sleep_lo_n_oe_n,
      .tx_activity_toggle_out, .tx_activity_toggle_oe_n, .rx_activity_toggle_out,
      .rx_activity_toggle_oe_n);
   usbsp_host_model u_usbsp_host_model (.ref_clk, .bus_suspend, .bus_resume, .bus_reset,
      .configured);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] m = '1);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata & m, exp);
   endtask
   task give_verdict();
      $display("comparisons %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      cyc(5);
      chk({sleep_hi_oe_n, sleep_lo_n_oe_n}, 2'b11);
      @(posedge ref_clk);
      srst <= 1'b0;
      cyc(3);
      chk({sleep_hi_out, sleep_lo_n_out, sleep_hi_oe_n}, 3'b100);
      rd(4'h0, 32'h3);
      rd(4'h2, 32'h0);
      u_usbsp_host_model.wake(0);
      cyc(4);
      chk(sleep_hi_out, 1'b1);
      wr(4'hC, 32'h7);
      rd(4'hC, 32'h7);
      u_usbsp_host_model.set_config();
      cyc(4);
      chk({sleep_hi_out, sleep_lo_n_out}, 2'b01);
      rd(4'h8, 32'h4, 32'h4);
      for (int i = 0; i < 3; i++)
      begin
         u_usbsp_host_model.suspend();
         cyc(4);
         chk({sleep_hi_out, sleep_lo_n_out, irq}, 3'b101);
         rd(4'h8, 32'h1);
         rd(4'h4, 32'h3);
         u_usbsp_host_model.wake(i);
         dev_resume <= (i == 2);
         @(posedge ref_clk);
         dev_resume <= 1'b0;
         cyc(4);
         chk({sleep_hi_out, sleep_lo_n_out, irq}, 3'b011);
         rd(4'h8, 32'h2);
      end
      @(posedge ref_clk);
      uart_tx_busy <= 1'b1;
      uart_rx_busy <= 1'b1;
      cyc(6);
      chk({tx_activity_toggle_out, rx_activity_toggle_out}, 2'b11);
      rd(4'h4, 32'hE);
      @(posedge ref_clk);
      uart_tx_busy <= 1'b0;
      uart_rx_busy <= 1'b0;
      cyc(2);
      chk({tx_activity_toggle_out, rx_activity_toggle_out}, 2'b11);
      wr(4'h0, 32'h18);
      cyc(3);
      chk({tx_activity_toggle_out, tx_activity_toggle_oe_n}, 2'b00);
      chk({rx_activity_toggle_out, rx_activity_toggle_oe_n}, 2'b11);
      @(posedge ref_clk);
      otp_susp_level4 <= 1'b0;
      otp_susp_od4 <= 1'b0;
      u_usbsp_host_model.suspend();
      cyc(4);
      chk({tx_activity_toggle_out, tx_activity_toggle_oe_n, rx_activity_toggle_oe_n}, 3'b001);
      // Resume pulse while frozen is lost
      @(posedge ref_clk);
      clk_en <= 1'b0;
      u_usbsp_host_model.wake(0);
      cyc(3);
      chk({sleep_hi_out, irq}, 2'b11);
      @(posedge ref_clk);
      clk_en <= 1'b1;
      cyc(3);
      chk({sleep_hi_out, sleep_lo_n_out}, 2'b10);
      // Device reset in mid-run, host drops its configuration
      u_usbsp_host_model.unconfig();
      srst <= 1'b1;
      cyc(2);
      chk({sleep_hi_oe_n, sleep_lo_n_oe_n, irq}, 3'b110);
      @(posedge ref_clk);
      srst <= 1'b0;
      cyc(3);
      chk({sleep_hi_out, sleep_lo_n_out, sleep_hi_oe_n}, 3'b100);
      u_usbsp_host_model.set_config();
      cyc(4);
      chk({sleep_hi_out, sleep_lo_n_out}, 2'b01);
      give_verdict();
   end
   // Hang guard, far beyond the test length
   initial
   begin
      #40000;
      err_total++;
      give_verdict();
   end
endmodule // test_usbsp_top
`default_nettype wire
